// file: pkg/ssm_pkg.sv
package ssm_pkg;
   localparam int unsigned CLK_HZ = 40_000_000;
   localparam int unsigned MS_NS = 1_000_000;
   localparam int unsigned CLK_NS = 25;
   localparam int unsigned MS_CYCLES = MS_NS / CLK_NS;
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_CFG = 8'h04;
   localparam logic [7:0] ADDR_DECEL = 8'h08;
   localparam logic [7:0] ADDR_TLIM = 8'h0c;
   localparam logic [7:0] ADDR_STATUS = 8'h10;
   localparam logic [7:0] ADDR_IRQ_STAT = 8'h14;
   localparam logic [7:0] ADDR_IRQ_MASK = 8'h18;
   localparam logic [7:0] ADDR_SPEED = 8'h1c;
   localparam int CTRL_QSTOP = 0;
   localparam int CTRL_ESTOP_ALLOC = 1;
   localparam int CTRL_REBOOT = 2;
   localparam int CFG_SRC = 0;
   localparam int CFG_FAULT_LSB = 4;
   localparam int CFG_OT_LSB = 8;
   localparam int CFG_MODE_LSB = 12;
   localparam logic [15:0] DECEL_RESET = 16'h03e8;
   localparam logic [8:0] TLIM_RESET = 9'h12c;
   localparam logic [8:0] TLIM_MAX = 9'h15e;
   localparam logic [2:0] MODE_MAX = 3'h6;
   localparam logic [1:0] OT_MAX = 2'h3;
   localparam logic [1:0] FAULT_MAX = 2'h2;
   localparam logic [15:0] RPM_STEP = 16'h03e8;
   localparam int IRQ_ESTOP = 0;
   localparam int IRQ_STOPPED = 1;
   localparam int IRQ_QSTOP_REFUSED = 2;
   typedef enum logic [2:0] {
      SSM_RUN = 3'b000,
      SSM_STOPPING = 3'b001,
      SSM_HELD = 3'b011,
      SSM_FORCED = 3'b010,
      SSM_READY = 3'b110
   } ssm_state_type;
   typedef enum logic [1:0] {
      SSM_POST_COAST = 2'h0,
      SSM_POST_BRAKE = 2'h1,
      SSM_POST_CLAMP = 2'h2,
      SSM_POST_RUN = 2'h3
   } ssm_post_type;
endpackage : ssm_pkg

// file: pkg/ssm_ramp_if.sv
`timescale 1ns/100ps
`default_nettype none
interface ssm_ramp_if;
   logic start;
   logic [15:0] speed_in;
   logic [15:0] decel_ms;
   logic [15:0] speed;
   logic done;
   modport ctrl (output start, output speed_in, output decel_ms, input speed, input done);
   modport ramp (input start, input speed_in, input decel_ms, output speed, output done);
endinterface : ssm_ramp_if
`default_nettype wire

// file: rtl/ssm_ramp.sv
`timescale 1ns/100ps
`default_nettype none
module ssm_ramp (
   input wire logic sys_clk_in,
   input wire logic rst_in,
   ssm_ramp_if.ramp rif
);
   logic [15:0] ms_cnt;
   logic [15:0] next_ms_cnt;
   logic [31:0] acc;
   logic [31:0] next_acc;
   logic [15:0] speed;
   logic [15:0] next_speed;
   logic [31:0] step;
   always_comb begin
      next_ms_cnt = ms_cnt;
      next_acc = acc;
      next_speed = speed;
      step = 32'(rif.decel_ms);
      if (rif.start) begin
         next_speed = rif.speed_in;
         next_ms_cnt = 16'h0000;
         next_acc = 32'h0000_0000;
      end else if (speed != 16'h0000) begin
         // one ms tick; decel 0 stops at once, else slope 1000 rpm per decel time, but never more than 1 rpm per ms, so slower when decel is below 1000
         if (ms_cnt == 16'(ssm_pkg::MS_CYCLES - 1)) begin
            next_ms_cnt = 16'h0000;
            if (step == 32'h0000_0000) begin
               next_speed = 16'h0000;
            end else begin
               next_acc = acc + 32'(ssm_pkg::RPM_STEP);
               if (next_acc >= step) begin
                  next_acc = next_acc - step;
                  next_speed = speed - 16'h0001;
               end
            end
         end else begin
            next_ms_cnt = ms_cnt + 16'h0001;
         end
      end
   end
   always_ff @(posedge sys_clk_in or posedge rst_in) begin
      if (rst_in) begin
         ms_cnt <= 16'h0000;
         acc <= 32'h0000_0000;
         speed <= 16'h0000;
      end else begin
         ms_cnt <= next_ms_cnt;
         acc <= next_acc;
         speed <= next_speed;
      end
   end
   assign rif.speed = speed;
   assign rif.done = (speed == 16'h0000);
endmodule : ssm_ramp
`default_nettype wire

// file: rtl/ssm_top.sv
`timescale 1ns/100ps
`default_nettype none
module ssm_top (
   input wire logic sys_clk_in,
   input wire logic rst_in,
   input wire logic [7:0] addr_in,
   input wire logic [31:0] wdata_in,
   input wire logic wr_in,
   input wire logic rd_in,
   output logic [31:0] rdata_out,
   output logic irq_out,
   input wire logic estop_in,
   input wire logic enable_op_in,
   input wire logic disable_op_in,
   input wire logic fault_in,
   input wire logic safe_state_in,
   input wire logic overtravel_in,
   input wire logic alarm_is_warning_in,
   output logic forced_stop_out,
   output logic drive_enable_out,
   output logic dynamic_brake_out,
   output logic zero_speed_ref_out,
   output logic zero_clamp_out,
   output logic [8:0] torque_limit_out,
   output logic [15:0] speed_ref_out,
   output logic [2:0] quick_stop_code_out
);
   ssm_ramp_if rif ();
   ssm_ramp u_ramp (.sys_clk_in(sys_clk_in), .rst_in(rst_in), .rif(rif));

   logic [2:0] ctrl, next_ctrl;
   logic [15:0] cfg, next_cfg;
   logic [15:0] decel, next_decel;
   logic [8:0] tlim, next_tlim;
   logic [15:0] speed, next_speed;
   logic [2:0] irq_stat, next_irq_stat;
   logic [2:0] irq_mask, next_irq_mask;
   logic src_sel, next_src_sel;
   logic [1:0] fault_m, next_fault_m;
   logic [1:0] ot_m, next_ot_m;
   logic [31:0] rdata, next_rdata;
   ssm_pkg::ssm_state_type state, next_state;
   ssm_pkg::ssm_post_type post, next_post;
   logic rev_brake, next_rev_brake;
   logic db_active, next_db_active;
   logic start;
   logic [2:0] mode_code;
   logic estop_alloc, estop_req, qstop_req, stop_req, ev_estop, ev_stop;

   // register file
   always_comb begin
      next_ctrl = ctrl;
      next_cfg = cfg;
      next_decel = decel;
      next_tlim = tlim;
      next_speed = speed;
      next_irq_mask = irq_mask;
      next_rdata = 32'h0000_0000;
      next_src_sel = src_sel;
      next_fault_m = fault_m;
      next_ot_m = ot_m;
      next_irq_stat = irq_stat;
      if (wr_in) begin
         if (addr_in == ssm_pkg::ADDR_CTRL) begin
            next_ctrl = wdata_in[2:0];
         end else if (addr_in == ssm_pkg::ADDR_CFG) begin
            next_cfg = wdata_in[15:0];
            if (wdata_in[ssm_pkg::CFG_MODE_LSB +: 3] > ssm_pkg::MODE_MAX) begin
               next_cfg[ssm_pkg::CFG_MODE_LSB +: 3] = cfg[ssm_pkg::CFG_MODE_LSB +: 3];
            end
            if (wdata_in[ssm_pkg::CFG_FAULT_LSB +: 2] > ssm_pkg::FAULT_MAX) begin
               next_cfg[ssm_pkg::CFG_FAULT_LSB +: 2] = cfg[ssm_pkg::CFG_FAULT_LSB +: 2];
            end
         end else if (addr_in == ssm_pkg::ADDR_DECEL) begin
            next_decel = wdata_in[15:0];
         end else if (addr_in == ssm_pkg::ADDR_TLIM) begin
            if (wdata_in[8:0] <= ssm_pkg::TLIM_MAX && wdata_in[31:9] == 23'h0) begin
               next_tlim = wdata_in[8:0];
            end
         end else if (addr_in == ssm_pkg::ADDR_IRQ_STAT) begin
            next_irq_stat = irq_stat & ~wdata_in[2:0];
         end else if (addr_in == ssm_pkg::ADDR_IRQ_MASK) begin
            next_irq_mask = wdata_in[2:0];
         end else if (addr_in == ssm_pkg::ADDR_SPEED) begin
            next_speed = wdata_in[15:0];
         end
      end
      // set wins over clear
      next_irq_stat = next_irq_stat | {qstop_req & estop_alloc, ev_stop, ev_estop};
      if (ctrl[ssm_pkg::CTRL_REBOOT]) begin
         next_src_sel = cfg[ssm_pkg::CFG_SRC];
         next_fault_m = cfg[ssm_pkg::CFG_FAULT_LSB +: 2];
         next_ot_m = cfg[ssm_pkg::CFG_OT_LSB +: 2];
         next_ctrl[ssm_pkg::CTRL_REBOOT] = 1'b0;
      end
      if (rd_in) begin
         if (addr_in == ssm_pkg::ADDR_CTRL) begin
            next_rdata = {29'h0, ctrl};
         end else if (addr_in == ssm_pkg::ADDR_CFG) begin
            next_rdata = {16'h0, cfg};
         end else if (addr_in == ssm_pkg::ADDR_DECEL) begin
            next_rdata = {16'h0, decel};
         end else if (addr_in == ssm_pkg::ADDR_TLIM) begin
            next_rdata = {23'h0, tlim};
         end else if (addr_in == ssm_pkg::ADDR_STATUS) begin
            next_rdata = {rif.speed, 10'h000, post, 1'b0, state};
         end else if (addr_in == ssm_pkg::ADDR_IRQ_STAT) begin
            next_rdata = {29'h0, irq_stat};
         end else if (addr_in == ssm_pkg::ADDR_IRQ_MASK) begin
            next_rdata = {29'h0, irq_mask};
         end else if (addr_in == ssm_pkg::ADDR_SPEED) begin
            next_rdata = {16'h0, speed};
         end
      end
   end

   always_comb begin
      estop_alloc = ctrl[ssm_pkg::CTRL_ESTOP_ALLOC];
      estop_req = estop_alloc & ~estop_in;
      qstop_req = ctrl[ssm_pkg::CTRL_QSTOP];
      case (cfg[ssm_pkg::CFG_MODE_LSB +: 3])
         3'h0: mode_code = 3'h0;
         3'h1: mode_code = 3'h1;
         3'h2: mode_code = 3'h2;
         3'h5: mode_code = 3'h5;
         3'h6: mode_code = 3'h6;
         default: mode_code = 3'h0;
      endcase
      // quick stop refused while the forced stop owns stopping
      stop_req = (fault_in & ~alarm_is_warning_in) | safe_state_in | overtravel_in
         | (qstop_req & ~estop_alloc);
   end

   // stop sequencer
   always_comb begin
      next_state = state;
      next_post = post;
      next_rev_brake = rev_brake;
      next_db_active = db_active;
      start = 1'b0;
      ev_estop = 1'b0;
      ev_stop = 1'b0;
      case (state)
         ssm_pkg::SSM_RUN: begin
            if (estop_req) begin
               next_state = ssm_pkg::SSM_FORCED;
               start = 1'b1;
               ev_estop = 1'b1;
               next_rev_brake = 1'b0;
               next_db_active = 1'b0;
               next_post = ssm_pkg::SSM_POST_COAST;
            end else if (stop_req) begin
               next_state = ssm_pkg::SSM_STOPPING;
               start = 1'b1;
               if (overtravel_in) begin
                  next_rev_brake = ot_m[1];
                  next_db_active = ~ot_m[1];
                  case (ot_m)
                     2'h1: next_post = ssm_pkg::SSM_POST_BRAKE;
                     2'h2: next_post = ssm_pkg::SSM_POST_CLAMP;
                     default: next_post = ssm_pkg::SSM_POST_COAST;
                  endcase
               end else begin
                  next_rev_brake = 1'b0;
                  next_db_active = (fault_m != 2'h2);
                  next_post = (fault_m == 2'h1) ? ssm_pkg::SSM_POST_BRAKE
                     : ssm_pkg::SSM_POST_COAST;
               end
            end
         end
         ssm_pkg::SSM_STOPPING: begin
            if (estop_req) begin
               next_state = ssm_pkg::SSM_FORCED;
               ev_estop = 1'b1;
               // drop reverse brake and braking so no stale mode outlives the stop
               next_rev_brake = 1'b0;
               next_db_active = 1'b0;
               next_post = ssm_pkg::SSM_POST_COAST;
            end else if (rif.done) begin
               next_state = ssm_pkg::SSM_HELD;
               next_rev_brake = 1'b0;
               next_db_active = 1'b0;
               ev_stop = 1'b1;
            end
         end
         ssm_pkg::SSM_HELD: begin
            if (estop_req) begin
               next_state = ssm_pkg::SSM_FORCED;
               ev_estop = 1'b1;
               next_post = ssm_pkg::SSM_POST_COAST;
            end else if (!stop_req && disable_op_in) begin
               next_state = ssm_pkg::SSM_READY;
            end
         end
         ssm_pkg::SSM_FORCED: begin
            // stays forced even once the input returns high
            if (disable_op_in && !estop_req) begin
               next_state = ssm_pkg::SSM_READY;
               next_post = ssm_pkg::SSM_POST_COAST;
            end
         end
         ssm_pkg::SSM_READY: begin
            if (estop_req) begin
               next_state = ssm_pkg::SSM_FORCED;
               ev_estop = 1'b1;
            end else if (enable_op_in && !stop_req) begin
               next_state = ssm_pkg::SSM_RUN;
               next_post = ssm_pkg::SSM_POST_RUN;
            end
         end
         default: next_state = ssm_pkg::SSM_READY;
      endcase
   end

   always_ff @(posedge sys_clk_in or posedge rst_in) begin
      if (rst_in) begin
         ctrl <= 3'h0;
         cfg <= 16'h0000;
         decel <= ssm_pkg::DECEL_RESET;
         tlim <= ssm_pkg::TLIM_RESET;
         speed <= 16'h0000;
         irq_stat <= 3'h0;
         irq_mask <= 3'h0;
         src_sel <= 1'b0;
         fault_m <= 2'h0;
         ot_m <= 2'h0;
         rdata <= 32'h0000_0000;
         state <= ssm_pkg::SSM_READY;
         post <= ssm_pkg::SSM_POST_COAST;
         rev_brake <= 1'b0;
         db_active <= 1'b0;
      end else begin
         ctrl <= next_ctrl;
         cfg <= next_cfg;
         decel <= next_decel;
         tlim <= next_tlim;
         speed <= next_speed;
         irq_stat <= next_irq_stat;
         irq_mask <= next_irq_mask;
         src_sel <= next_src_sel;
         fault_m <= next_fault_m;
         ot_m <= next_ot_m;
         rdata <= next_rdata;
         state <= next_state;
         post <= next_post;
         rev_brake <= next_rev_brake;
         db_active <= next_db_active;
      end
   end

   assign rif.start = start;
   assign rif.speed_in = speed;
   // bus objects ramp is external when source is 0
   assign rif.decel_ms = src_sel ? decel : 16'h0000;
   assign rdata_out = rdata;
   assign irq_out = |(irq_stat & irq_mask);
   assign forced_stop_out = (state == ssm_pkg::SSM_FORCED);
   assign drive_enable_out = (state == ssm_pkg::SSM_RUN) | (state == ssm_pkg::SSM_STOPPING
      & rev_brake) | (state == ssm_pkg::SSM_HELD & post == ssm_pkg::SSM_POST_CLAMP);
   assign dynamic_brake_out = (state == ssm_pkg::SSM_STOPPING & db_active)
      | (state == ssm_pkg::SSM_HELD & post == ssm_pkg::SSM_POST_BRAKE);
   assign zero_speed_ref_out = rev_brake;
   assign zero_clamp_out = (state == ssm_pkg::SSM_HELD) & (post == ssm_pkg::SSM_POST_CLAMP);
   assign torque_limit_out = tlim;
   assign speed_ref_out = rev_brake ? 16'h0000 : rif.speed;
   assign quick_stop_code_out = src_sel ? mode_code : 3'h0;

   forced_hold_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
      state == ssm_pkg::SSM_FORCED && !disable_op_in |=> state == ssm_pkg::SSM_FORCED)
      else $error("forced stop left without disable");
   estop_enter_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
      estop_alloc && !estop_in && state == ssm_pkg::SSM_RUN |=> forced_stop_out)
      else $error("forced stop not entered");
   ready_first_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
      $past(state) == ssm_pkg::SSM_FORCED |-> state != ssm_pkg::SSM_RUN)
      else $error("run directly from forced stop");
   status_flag_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
      $rose(forced_stop_out) |-> $past(estop_req))
      else $error("forced flag without cause");
   rev_zero_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
      zero_speed_ref_out |-> state == ssm_pkg::SSM_STOPPING && speed_ref_out == 16'h0000)
      else $error("speed ref not zero in reverse brake");
   tlim_range_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
      torque_limit_out <= ssm_pkg::TLIM_MAX)
      else $error("torque limit out of range");
   clamp_drive_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
      zero_clamp_out |-> drive_enable_out && !dynamic_brake_out)
      else $error("clamp without position loop");
   qstop_block_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
      state == ssm_pkg::SSM_RUN && estop_alloc && estop_in && qstop_req && !fault_in
      && !safe_state_in && !overtravel_in |=> state == ssm_pkg::SSM_RUN)
      else $error("quick stop honoured while allocated");
   warn_run_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
      state == ssm_pkg::SSM_RUN && !estop_req && fault_in && alarm_is_warning_in
      && !safe_state_in && !overtravel_in && !qstop_req |=> state == ssm_pkg::SSM_RUN)
      else $error("warning alarm stopped motor");
endmodule : ssm_top
`default_nettype wire

// file: verif/ssm_host_model.sv
`timescale 1ns/100ps
`default_nettype none
module ssm_host_model (
   input wire logic sys_clk_in,
   output logic estop_out,
   output logic enable_op_out,
   output logic disable_op_out
);
   initial begin
      estop_out = 1'b1;
      enable_op_out = 1'b0;
      disable_op_out = 1'b0;
   end
   task automatic set_estop(input logic v);
      @(posedge sys_clk_in) estop_out <= v;
   endtask : set_estop
   task automatic enable_operation();
      @(posedge sys_clk_in) enable_op_out <= 1'b1;
      @(posedge sys_clk_in) enable_op_out <= 1'b0;
   endtask : enable_operation
   task automatic disable_operation();
      @(posedge sys_clk_in) disable_op_out <= 1'b1;
      @(posedge sys_clk_in) disable_op_out <= 1'b0;
   endtask : disable_operation
   // leave a stop: disable first, then enable again
   task automatic recover();
      disable_operation();
      enable_operation();
   endtask : recover
endmodule : ssm_host_model
`default_nettype wire

// file: verif/tb.sv
`timescale 1ns/100ps
`default_nettype none
module tb;
   logic sys_clk_in = 1'b0;
   logic rst_in = 1'b1;
   logic [7:0] addr_in = 8'h00;
   logic [31:0] wdata_in = 32'h0000_0000;
   logic wr_in = 1'b0;
   logic rd_in = 1'b0;
   logic fault_in = 1'b0;
   logic overtravel_in = 1'b0;
   logic safe_state_in = 1'b0;
   logic alarm_is_warning_in = 1'b0;
   logic estop, enable_op, disable_op;
   logic [31:0] rdata_out;
   logic irq_out, forced_stop_out, drive_enable_out, dynamic_brake_out;
   logic zero_speed_ref_out, zero_clamp_out;
   logic [8:0] torque_limit_out;
   logic [15:0] speed_ref_out;
   logic [2:0] quick_stop_code_out;
   logic [31:0] rv;
   logic [2:0] code_tbl [0:6] = '{3'h0, 3'h1, 3'h2, 3'h0, 3'h0, 3'h5, 3'h6};
   int n_mismatch = 0;
   int n_checks = 0;

   always #12.5 sys_clk_in = ~sys_clk_in;

   ssm_host_model u_host (.sys_clk_in(sys_clk_in), .estop_out(estop),
      .enable_op_out(enable_op), .disable_op_out(disable_op));

   ssm_top u_dut (.sys_clk_in(sys_clk_in), .rst_in(rst_in), .addr_in(addr_in),
      .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
      .irq_out(irq_out), .estop_in(estop), .enable_op_in(enable_op),
      .disable_op_in(disable_op), .fault_in(fault_in), .safe_state_in(safe_state_in),
      .overtravel_in(overtravel_in), .alarm_is_warning_in(alarm_is_warning_in),
      .forced_stop_out(forced_stop_out), .drive_enable_out(drive_enable_out),
      .dynamic_brake_out(dynamic_brake_out), .zero_speed_ref_out(zero_speed_ref_out),
      .zero_clamp_out(zero_clamp_out), .torque_limit_out(torque_limit_out),
      .speed_ref_out(speed_ref_out), .quick_stop_code_out(quick_stop_code_out));

   task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("BAD %s expected %h seen %h", name, exp, seen);
      end
   endtask : chk

   task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge sys_clk_in) begin
         addr_in <= a;
         wdata_in <= d;
         wr_in <= 1'b1;
      end
      @(posedge sys_clk_in) wr_in <= 1'b0;
   endtask : reg_wr

   task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge sys_clk_in) begin
         addr_in <= a;
         rd_in <= 1'b1;
      end
      @(posedge sys_clk_in) rd_in <= 1'b0;
      #1 d = rdata_out;
   endtask : reg_rd

   task automatic cycles(input int n);
      repeat (n) @(posedge sys_clk_in);
      #1;
   endtask : cycles

   // poll status until the stop has finished, bounded
   task automatic wait_held();
      int i;
      i = 0;
      reg_rd(ssm_pkg::ADDR_STATUS, rv);
      while (rv[2:0] !== ssm_pkg::SSM_HELD && i < 1100) begin
         cycles(40);
         reg_rd(ssm_pkg::ADDR_STATUS, rv);
         i++;
      end
      chk("stop_done", {29'h0, rv[2:0]}, {29'h0, ssm_pkg::SSM_HELD});
   endtask : wait_held

   task automatic chk_state(input string name, input logic [2:0] st);
      reg_rd(ssm_pkg::ADDR_STATUS, rv);
      chk(name, {29'h0, rv[2:0]}, {29'h0, st});
   endtask : chk_state

   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : report_and_stop

   initial begin
      repeat (99000) @(posedge sys_clk_in);
      n_mismatch++;
      report_and_stop();
   end

   initial begin
      repeat (6) @(posedge sys_clk_in);
      rst_in <= 1'b0;
      cycles(1);
      chk("tlim_out", {23'h0, torque_limit_out}, 32'h0000_012c);
      reg_rd(ssm_pkg::ADDR_DECEL, rv);
      chk("decel", rv, 32'h0000_03e8);
      reg_wr(ssm_pkg::ADDR_TLIM, 32'h0000_015f);
      reg_rd(ssm_pkg::ADDR_TLIM, rv);
      chk("tlim_over", rv, 32'h0000_012c);
      reg_wr(ssm_pkg::ADDR_TLIM, 32'h0000_015e);
      reg_rd(ssm_pkg::ADDR_TLIM, rv);
      chk("tlim_max", rv, 32'h0000_015e);
      reg_wr(ssm_pkg::ADDR_DECEL, 32'h0000_ffff);
      reg_rd(ssm_pkg::ADDR_DECEL, rv);
      chk("decel_max", rv, 32'h0000_ffff);
      reg_wr(ssm_pkg::ADDR_DECEL, 32'h0000_0000);
      reg_wr(ssm_pkg::ADDR_SPEED, 32'h0000_0002);
      // unallocated forced stop input has no effect
      u_host.enable_operation();
      chk_state("run", ssm_pkg::SSM_RUN);
      u_host.set_estop(1'b0);
      cycles(3);
      chk("forced_unalloc", {31'h0, forced_stop_out}, 32'h0000_0000);
      chk_state("run_unalloc", ssm_pkg::SSM_RUN);
      u_host.set_estop(1'b1);
      // source select waits for reboot
      reg_wr(ssm_pkg::ADDR_CFG, 32'h0000_6211);
      cycles(2);
      chk("code_src0", {29'h0, quick_stop_code_out}, 32'h0000_0000);
      reg_wr(ssm_pkg::ADDR_CTRL, 32'h0000_0004);
      for (int m = 0; m < 7; m++) begin
         reg_wr(ssm_pkg::ADDR_CFG, 32'h0000_0211 | (m << 12));
         cycles(2);
         chk("qs_code", {29'h0, quick_stop_code_out}, {29'h0, code_tbl[m]});
      end
      reg_wr(ssm_pkg::ADDR_CFG, 32'h0000_7211);
      cycles(2);
      chk("code_bad_mode", {29'h0, quick_stop_code_out}, 32'h0000_0006);
      reg_wr(ssm_pkg::ADDR_CTRL, 32'h0000_0002);
      reg_wr(ssm_pkg::ADDR_IRQ_MASK, 32'h0000_0007);
      reg_wr(ssm_pkg::ADDR_CTRL, 32'h0000_0003);
      cycles(2);
      reg_rd(ssm_pkg::ADDR_IRQ_STAT, rv);
      chk("qs_refused", {31'h0, rv[2]}, 32'h0000_0001);
      chk_state("run_qs", ssm_pkg::SSM_RUN);
      reg_wr(ssm_pkg::ADDR_CTRL, 32'h0000_0002);
      reg_wr(ssm_pkg::ADDR_IRQ_STAT, 32'h0000_0004);
      // forced stop held until disable, then ready and run
      u_host.set_estop(1'b0);
      cycles(3);
      chk("forced", {31'h0, forced_stop_out}, 32'h0000_0001);
      chk("irq", {31'h0, irq_out}, 32'h0000_0001);
      chk("coast", {31'h0, drive_enable_out}, 32'h0000_0000);
      reg_rd(ssm_pkg::ADDR_IRQ_STAT, rv);
      chk("irq_estop", {31'h0, rv[0]}, 32'h0000_0001);
      reg_wr(ssm_pkg::ADDR_IRQ_STAT, 32'h0000_0007);
      reg_rd(ssm_pkg::ADDR_IRQ_STAT, rv);
      chk("irq_clr", rv, 32'h0000_0000);
      chk("irq_low", {31'h0, irq_out}, 32'h0000_0000);
      u_host.enable_operation();
      u_host.set_estop(1'b1);
      cycles(3);
      chk_state("still_forced", ssm_pkg::SSM_FORCED);
      chk("still_forced_out", {31'h0, forced_stop_out}, 32'h0000_0001);
      u_host.disable_operation();
      chk_state("ready", ssm_pkg::SSM_READY);
      u_host.enable_operation();
      chk_state("run_again", ssm_pkg::SSM_RUN);
      chk("forced_clr", {31'h0, forced_stop_out}, 32'h0000_0000);
      // alarm treated as warning
      @(posedge sys_clk_in) alarm_is_warning_in <= 1'b1;
      fault_in <= 1'b1;
      cycles(5);
      chk_state("warn_run", ssm_pkg::SSM_RUN);
      chk("warn_drive", {31'h0, drive_enable_out}, 32'h0000_0001);
      @(posedge sys_clk_in) fault_in <= 1'b0;
      alarm_is_warning_in <= 1'b0;
      cycles(2);
      // overtravel: reverse brake then zero clamp
      @(posedge sys_clk_in) overtravel_in <= 1'b1;
      cycles(3);
      chk("zero_ref", {31'h0, zero_speed_ref_out}, 32'h0000_0001);
      chk("speed_ref", {16'h0, speed_ref_out}, 32'h0000_0000);
      chk("rb_tlim", {23'h0, torque_limit_out}, 32'h0000_015e);
      wait_held();
      chk("ot_post", {30'h0, rv[5:4]}, 32'h0000_0002);
      chk("clamp", {31'h0, zero_clamp_out}, 32'h0000_0001);
      @(posedge sys_clk_in) overtravel_in <= 1'b0;
      u_host.recover();
      chk_state("run_ot", ssm_pkg::SSM_RUN);
      // class one alarm: brake then brake hold
      reg_wr(ssm_pkg::ADDR_IRQ_STAT, 32'h0000_0007);
      @(posedge sys_clk_in) fault_in <= 1'b1;
      cycles(3);
      chk("db_stop", {31'h0, dynamic_brake_out}, 32'h0000_0001);
      wait_held();
      chk("fault_post", {30'h0, rv[5:4]}, 32'h0000_0001);
      chk("db_hold", {31'h0, dynamic_brake_out}, 32'h0000_0001);
      chk("db_drive", {31'h0, drive_enable_out}, 32'h0000_0000);
      reg_rd(ssm_pkg::ADDR_IRQ_STAT, rv);
      chk("irq_stopped", {31'h0, rv[1]}, 32'h0000_0001);
      @(posedge sys_clk_in) fault_in <= 1'b0;
      u_host.recover();
      chk_state("run_end", ssm_pkg::SSM_RUN);
      // safe state with no speed left: brake hold at once
      reg_wr(ssm_pkg::ADDR_SPEED, 32'h0000_0000);
      @(posedge sys_clk_in) safe_state_in <= 1'b1;
      cycles(4);
      reg_rd(ssm_pkg::ADDR_STATUS, rv);
      chk("safe_held", {26'h0, rv[5:0]}, 32'h0000_0013);
      chk("safe_db", {31'h0, dynamic_brake_out}, 32'h0000_0001);
      report_and_stop();
   end
endmodule : tb
`default_nettype wire
